// [design/iepb_pkg.sv]
// Purpose: Shared constants and types for the interrupt enable and priority bank.
// Assumes: APB slave with 32-bit data, 16-bit registers in the low half of each word.
// Notes: Summary of operation below.
package iepb_pkg;
	localparam logic [11:0] IEPB_OFS_ENABLE4 = 12'h000;
	localparam logic [11:0] IEPB_OFS_PRIO0 = 12'h004;
	localparam logic [11:0] IEPB_OFS_PRIO1 = 12'h008;
	localparam logic [11:0] IEPB_OFS_PRIO2 = 12'h00C;
	localparam logic [11:0] IEPB_OFS_PRIO3 = 12'h010;
	localparam logic [11:0] IEPB_OFS_PRIO4 = 12'h014;
	localparam int IEPB_NUM_PRIO_REGS = 5;
	localparam int IEPB_NUM_SRC = 4 * IEPB_NUM_PRIO_REGS - 1;
	// Writable bit masks; everything else is unimplemented.
	localparam logic [15:0] IEPB_ENABLE4_MASK = 16'h007E;
	localparam logic [15:0] IEPB_PRIO_MASK_FULL = 16'h7777;
	localparam logic [15:0] IEPB_PRIO_MASK_GRP3 = 16'h0777;
	localparam logic [15:0] IEPB_ENABLE4_RESET = 16'h0000;
	localparam logic [15:0] IEPB_PRIO_RESET_FULL = 16'h4444;
	localparam logic [15:0] IEPB_PRIO_RESET_GRP3 = 16'h0444;
	localparam int IEPB_CAN_TX_BIT = 6;
	localparam int IEPB_DMA7_BIT = 5;
	localparam int IEPB_DMA6_BIT = 4;
	localparam int IEPB_CHECKSUM_BIT = 3;
	localparam int IEPB_UART_B_ERR_BIT = 2;
	localparam int IEPB_UART_A_ERR_BIT = 1;
	localparam logic [2:0] IEPB_PRIO_OFF = 3'h0;
	typedef struct packed
	{
		logic [2:0] timer_one_int_prio;
		logic [2:0] compare_one_int_prio;
		logic [2:0] capture_one_int_prio;
		logic [2:0] ext_irq_zero_prio;
		logic [2:0] timer_two_int_prio;
		logic [2:0] compare_two_int_prio;
		logic [2:0] capture_two_int_prio;
		logic [2:0] dma_ch0_done_prio;
		logic [2:0] uart_a_rx_prio;
		logic [2:0] spi_a_event_prio;
		logic [2:0] spi_a_error_prio;
		logic [2:0] timer_three_int_prio;
		logic [2:0] dma_ch1_done_prio;
		logic [2:0] adc_done_prio;
		logic [2:0] uart_a_tx_prio;
		logic [2:0] pin_change_prio;
		logic [2:0] comparator_event_prio;
		logic [2:0] i2c_master_event_prio;
		logic [2:0] i2c_slave_event_prio;
	} iepb_prio_type;
	typedef struct packed
	{
		logic can_tx_request_int_en;
		logic dma_ch7_done_int_en;
		logic dma_ch6_done_int_en;
		logic checksum_gen_int_en;
		logic uart_b_error_int_en;
		logic uart_a_error_int_en;
	} iepb_enable_type;
endpackage

// [design/iepb_prio_field.sv]
// Purpose: One priority register with masked write and per-field qualifier.
// Assumes: Write strobe from the APB decode of the same clock domain.
// Notes: Empty bits are held at zero by the mask.
`timescale 1ns/100ps
module iepb_prio_field
	import iepb_pkg::*;
#(
	parameter logic [15:0] WMASK = 16'h7777,
	parameter logic [15:0] RESET_VAL = 16'h4444
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	output logic [15:0] value,
	output logic [3:0] field_live
);
	logic [15:0] prio_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prio_r <= RESET_VAL;
		else if (wr_en)
			prio_r <= wr_data & WMASK;
	end
	assign value = prio_r;
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_live
			// A zero code turns the source off; any other code is its level.
			assign field_live[g] = (prio_r[g*4 +: 3] != IEPB_PRIO_OFF);
		end
	endgenerate
endmodule // iepb_prio_field

// [design/iepb_bank.sv]
// Purpose: APB register bank for interrupt enable group 4 and priority groups 0 to 4.
// Assumes: Single pclk domain, APB slave with byte strobes, zero wait states.
// Notes: Unmapped addresses read zero, ignore writes and answer pslverr.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
module iepb_bank
	import iepb_pkg::*;
#(
	parameter bit HAS_CAN = 1'b1
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output iepb_enable_type enable_out,
	output iepb_prio_type prio_out,
	output logic [IEPB_NUM_SRC-1:0] prio_qual,
	output logic [5:0] enable_qual
);
	////////////////////////////////////////////////////////////////////////////
	logic [15:0] enable4_r;
	logic [15:0] prio_val [IEPB_NUM_PRIO_REGS];
	logic [3:0] prio_live [IEPB_NUM_PRIO_REGS];
	logic [15:0] wdata16;
	logic [15:0] rd16;
	logic access;
	logic hit;

	function automatic logic [2:0] prio_index(input logic [11:0] a);
		case (a)
			IEPB_OFS_PRIO0: prio_index = 3'h0;
			IEPB_OFS_PRIO1: prio_index = 3'h1;
			IEPB_OFS_PRIO2: prio_index = 3'h2;
			IEPB_OFS_PRIO3: prio_index = 3'h3;
			IEPB_OFS_PRIO4: prio_index = 3'h4;
			default: prio_index = 3'h7;
		endcase
	endfunction

	assign access = psel && penable;
	assign pready = 1'b1;
	assign hit = (paddr == IEPB_OFS_ENABLE4) || (prio_index(paddr) != 3'h7);
	assign pslverr = access && !hit;
	// Byte strobes select which halves of the 16-bit register change.
	assign wdata16[7:0] = pstrb[0] ? pwdata[7:0] : 8'h00;
	assign wdata16[15:8] = pstrb[1] ? pwdata[15:8] : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	logic [15:0] strb_mask;
	assign strb_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			enable4_r <= IEPB_ENABLE4_RESET;
		else if (access && pwrite && paddr == IEPB_OFS_ENABLE4)
			enable4_r <= (enable4_r & ~strb_mask) | (wdata16 & strb_mask & IEPB_ENABLE4_MASK);
	end

	genvar i;
	generate
		for (i = 0; i < IEPB_NUM_PRIO_REGS; i++)
		begin : g_prio
			localparam logic [15:0] M = (i == 3) ? IEPB_PRIO_MASK_GRP3 : IEPB_PRIO_MASK_FULL;
			localparam logic [15:0] RV = (i == 3) ? IEPB_PRIO_RESET_GRP3 : IEPB_PRIO_RESET_FULL;
			logic wr;
			assign wr = access && pwrite && (prio_index(paddr) == 3'(i));
			iepb_prio_field #(.WMASK(M), .RESET_VAL(RV)) u_reg
			(
				.pclk(pclk),
				.presetn(presetn),
				.wr_en(wr),
				.wr_data((prio_val[i] & ~strb_mask) | (wdata16 & strb_mask)),
				.value(prio_val[i]),
				.field_live(prio_live[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		rd16 = 16'h0000;
		if (paddr == IEPB_OFS_ENABLE4)
			rd16 = enable4_r;
		else if (prio_index(paddr) != 3'h7)
			rd16 = prio_val[prio_index(paddr)];
	end
	logic [31:0] prdata_r;
	// Read data is captured at the end of the setup cycle and stands through the access cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h00000000;
		else if (psel && !penable)
			prdata_r <= {16'h0000, rd16};
	end
	assign prdata = prdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Field placement; levels 1..7 pass through unchanged to the arbiter.
	assign prio_out.timer_one_int_prio = prio_val[0][14:12];
	assign prio_out.compare_one_int_prio = prio_val[0][10:8];
	assign prio_out.capture_one_int_prio = prio_val[0][6:4];
	assign prio_out.ext_irq_zero_prio = prio_val[0][2:0];
	assign prio_out.timer_two_int_prio = prio_val[1][14:12];
	assign prio_out.compare_two_int_prio = prio_val[1][10:8];
	assign prio_out.capture_two_int_prio = prio_val[1][6:4];
	assign prio_out.dma_ch0_done_prio = prio_val[1][2:0];
	assign prio_out.uart_a_rx_prio = prio_val[2][14:12];
	assign prio_out.spi_a_event_prio = prio_val[2][10:8];
	assign prio_out.spi_a_error_prio = prio_val[2][6:4];
	assign prio_out.timer_three_int_prio = prio_val[2][2:0];
	assign prio_out.dma_ch1_done_prio = prio_val[3][10:8];
	assign prio_out.adc_done_prio = prio_val[3][6:4];
	assign prio_out.uart_a_tx_prio = prio_val[3][2:0];
	assign prio_out.pin_change_prio = prio_val[4][14:12];
	assign prio_out.comparator_event_prio = prio_val[4][10:8];
	assign prio_out.i2c_master_event_prio = prio_val[4][6:4];
	assign prio_out.i2c_slave_event_prio = prio_val[4][2:0];

	// Bit order matches the struct, first member at the top.
	assign prio_qual = {prio_live[0][3], prio_live[0][2], prio_live[0][1], prio_live[0][0],
		prio_live[1][3], prio_live[1][2], prio_live[1][1], prio_live[1][0],
		prio_live[2][3], prio_live[2][2], prio_live[2][1], prio_live[2][0],
		prio_live[3][2], prio_live[3][1], prio_live[3][0],
		prio_live[4][3], prio_live[4][2], prio_live[4][1], prio_live[4][0]};

	assign enable_out.can_tx_request_int_en = enable4_r[IEPB_CAN_TX_BIT] & HAS_CAN;
	assign enable_out.dma_ch7_done_int_en = enable4_r[IEPB_DMA7_BIT];
	assign enable_out.dma_ch6_done_int_en = enable4_r[IEPB_DMA6_BIT];
	assign enable_out.checksum_gen_int_en = enable4_r[IEPB_CHECKSUM_BIT];
	assign enable_out.uart_b_error_int_en = enable4_r[IEPB_UART_B_ERR_BIT];
	assign enable_out.uart_a_error_int_en = enable4_r[IEPB_UART_A_ERR_BIT];
	assign enable_qual = enable_out;
endmodule // iepb_bank

// [bench/iepb_bank_assertions.sv]
// Purpose: Port-level checks of the enable and priority bank.
// Assumes: One pclk domain, zero-wait APB slave.
// Notes: Bound to every iepb_bank instance.
`timescale 1ns/100ps
module iepb_bank_assertions
	import iepb_pkg::*;
#(
	parameter bit HAS_CAN = 1'b1
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire iepb_enable_type enable_out,
	input wire iepb_prio_type prio_out,
	input wire logic [IEPB_NUM_SRC-1:0] prio_qual,
	input wire logic [5:0] enable_qual
);
	logic acc;
	logic rd;
	logic [18:0] nz;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	always_comb
		for (int i = 0; i < 19; i++) nz[i] = |prio_out[3*i +: 3];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_map_err: assert property (acc |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'h0))
		else $error("pslverr wrong");
	a_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_en_read: assert property (rd && paddr == 12'h000 |-> prdata[15:7] == 9'h0 && !prdata[0])
		else $error("enable empty bits not zero");
	a_prio0_read: assert property (rd && paddr == 12'h004 |-> prdata[15:0] == {1'b0, prio_out[56:54], 1'b0,
		prio_out[53:51], 1'b0, prio_out[50:48], 1'b0, prio_out[47:45]})
		else $error("group 0 read wrong");
	a_prio3_read: assert property (rd && paddr == 12'h010 |-> prdata[15:0] == {5'h0, prio_out[20:18], 1'b0,
		prio_out[17:15], 1'b0, prio_out[14:12]})
		else $error("group 3 read wrong");
	a_en_write: assert property (acc && pwrite && paddr == 12'h000 && pstrb[0] |=>
		enable_out == ($past(pwdata[6:1]) & {HAS_CAN, 5'h1F}))
		else $error("enable write wrong");
	a_prio4_write: assert property (acc && pwrite && paddr == 12'h014 && pstrb[1:0] == 2'h3 |=>
		prio_out[11:0] == $past({pwdata[14:12], pwdata[10:8], pwdata[6:4], pwdata[2:0]}))
		else $error("group 4 write wrong");
	a_qual_nz: assert property (prio_qual[18:0] == nz)
		else $error("priority qualifier wrong");
	a_en_qual: assert property (enable_qual == enable_out)
		else $error("enable qualifier wrong");
	a_reset_val: assert property ($rose(presetn) |-> prio_out == {19{3'h4}} && enable_out == 6'h0)
		else $error("reset value wrong");
endmodule // iepb_bank_assertions
bind iepb_bank iepb_bank_assertions #(.HAS_CAN(HAS_CAN)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .enable_out(enable_out), .prio_out(prio_out), .prio_qual(prio_qual),
	.enable_qual(enable_qual));

// [bench/tb.sv]
// Purpose: Self-checking bench of the enable and priority bank.
// Assumes: Second instance is built without the CAN controller.
// Notes: prdata and pslverr are taken at the completing edge, other outputs 1 ns after it.
`timescale 1ns/100ps
module tb
	import iepb_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] pstrb = 0;
	iepb_enable_type en, en2;
	iepb_prio_type pr;
	logic [IEPB_NUM_SRC-1:0] pq;
	logic [5:0] eq;
	logic [15:0] rst_tbl [6] = '{16'h0000, 16'h4444, 16'h4444, 16'h4444, 16'h0444, 16'h4444};
	int bad_count = 0, check_count = 0, cyc = 0;
	initial forever #20 pclk = ~pclk;
	iepb_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_out(en),
		.prio_out(pr), .prio_qual(pq), .enable_qual(eq));
	iepb_bank #(.HAS_CAN(1'b0)) uut_nocan (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
		.enable_out(en2), .prio_out(), .prio_qual(), .enable_qual());
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		{psel, penable, paddr, pwrite, pwdata, pstrb} <= {2'b10, a, w, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic t_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			apb(i * 4, 1'b0, 0, 4'h0);
			chk("reset value", rd, {16'h0, rst_tbl[i]});
		end
		chk("reset qualifiers", {pq[18:0], en}, {19'h7FFFF, 6'h0});
		$display("test reset done");
	endtask
	task automatic t_enable();
		apb(12'h000, 1'b1, 32'hFFFFFFFF, 4'hF);
		apb(12'h000, 1'b0, 0, 4'h0);
		chk("enable read", rd, 32'h7E);
		chk("enable out", {en, en2}, {6'h3F, 6'h1F});
		apb(12'h000, 1'b1, 32'h2, 4'hF);
		chk("uart a error enable", en, 6'h01);
		$display("test enable done");
	endtask
	task automatic t_prio();
		for (int i = 1; i < 6; i++)
		begin
			apb(i * 4, 1'b1, 32'hFFFFFFFF, 4'hF);
			apb(i * 4, 1'b0, 0, 4'h0);
			chk("priority mask", rd, (i == 4) ? 32'h0777 : 32'h7777);
		end
		chk("all level 7", pr, {19{3'h7}});
		for (int i = 1; i < 6; i++) apb(i * 4, 1'b1, 32'h1111, 4'h3);
		chk("all level 1", {pr, pq[18:0]}, {{19{3'h1}}, 19'h7FFFF});
		apb(12'h00C, 1'b1, 32'h3652, 4'h3);
		chk("group 2 fields", {pr.uart_a_rx_prio, pr.spi_a_event_prio, pr.spi_a_error_prio, pr.timer_three_int_prio},
			{3'h3, 3'h6, 3'h5, 3'h2});
		apb(12'h004, 1'b1, 32'h0, 4'h1);
		apb(12'h004, 1'b0, 0, 4'h0);
		chk("byte strobe", rd, 32'h1100);
		chk("code zero", pq[18:15], 4'hC);
		$display("test priority done");
	endtask
	task automatic t_unmapped();
		apb(12'h018, 1'b1, 32'hFFFF, 4'hF);
		apb(12'h018, 1'b0, 0, 4'h0);
		chk("unmapped read", {rd, er}, {32'h0, 1'b1});
		$display("test unmapped done");
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			test_done();
		end
	end
	initial
	begin
		t_reset();
		t_enable();
		t_prio();
		t_unmapped();
		t_reset();
		test_done();
	end
endmodule // tb
